/* rtl/qpwm_counter.sv */
`timescale 1ns/1ns
// Summary of operation
// - quadrature on counter clock, x1/x2/x4 at 21:20
// - phase a count, b start, index reload
// - index gives tc: load zero or period
// - count at 0 or ffff pulses cc, reload
// - tc/cc capture count, shift old capture
// - capture value shows event cause
// - direction bit: 0 up, 1 down
// - x1: a rising counts by phase b
// - x2, x4 count two, four times faster
// - function 011 at 26:24 selects quadrature
// - cc/ov/un act on line: toggle/clear/set
// - alignment follows direction field 17:16
// - tc with pending switch swaps buffers
// - switch pends to tc; level never switches
// - center mode: tc clears, cc toggles
// - reload initialises count; cc on equality
// - kill blocks both lines; optional stop
// - sync kill until tc; async while present
module qpwm_counter
   import qpwm_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        sys_rst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // triggers from pins
   input  wire logic        count_trigger,
   input  wire logic        start_trigger,
   input  wire logic        reload_trigger,
   input  wire logic        kill_trigger,
   // outputs
   output logic             line_out,
   output logic             line_out_compl,
   output logic             compare_match,
   output logic             terminal_count
);

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers and edge detection
   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;
   logic [3:0] prev_reg;
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_reg <= 4'h0;
         sync2_reg <= 4'h0;
         prev_reg  <= 4'h0;
      end else begin
         sync1_reg <= {kill_trigger, reload_trigger, start_trigger,
                       count_trigger};
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end
   // phase a on count, phase b on start, index on reload
   wire encoder_phase_a = sync2_reg[0];
   wire encoder_phase_b = sync2_reg[1];
   wire a_rise  = sync2_reg[0] & ~prev_reg[0];
   wire a_fall  = ~sync2_reg[0] & prev_reg[0];
   wire b_edge  = sync2_reg[1] ^ prev_reg[1];
   wire a_edge  = a_rise | a_fall;
   wire index_rise = sync2_reg[2] & ~prev_reg[2];
   wire kill_lvl   = sync2_reg[3];
   wire kill_rise  = sync2_reg[3] & ~prev_reg[3];

   ////////////////////////////////////////////////////////////////////
   // registers
   logic [31:0] ctrl_reg;
   logic [15:0] count_reg, count_next;
   logic [15:0] cmp_reg, cmpbuf_reg, per_reg, perbuf_reg;
   logic [15:0] cap_reg, capbuf_reg;
   action_t     action_reg;
   logic        down_reg, down_next;
   logic        running_reg;
   logic        switch_reg;
   logic        sync_killed_reg;
   logic        q_moved_reg;

   wire func_t     func_sel = func_t'(ctrl_reg[CTL_FUNC_LO +: 3]);
   wire dir_mode_t dir_sel  = dir_mode_t'(ctrl_reg[CTL_UPDN_LO +: 2]);
   wire quad_t     quad_sel = quad_t'(ctrl_reg[CTL_QUAD_LO +: 2]);
   wire enabled   = ctrl_reg[CTL_ENABLE];
   wire is_quad   = enabled & (func_sel == FUNC_QUAD);
   wire is_pwm    = enabled & (func_sel == FUNC_PWM);
   wire stop_kill = ctrl_reg[CTL_STOPKILL];
   wire sync_kill = ctrl_reg[CTL_SYNCKILL];

   ////////////////////////////////////////////////////////////////////
   // apb decode, zero wait states
   wire apb_setup = psel & ~penable;
   wire apb_wr    = psel & penable & pwrite;
   wire wr_ctrl   = apb_wr & (paddr == ADDR_CTRL);
   wire wr_count  = apb_wr & (paddr == ADDR_COUNT);
   wire wr_cmp    = apb_wr & (paddr == ADDR_CMP);
   wire wr_cmpbuf = apb_wr & (paddr == ADDR_CMPBUF);
   wire wr_per    = apb_wr & (paddr == ADDR_PER);
   wire wr_perbuf = apb_wr & (paddr == ADDR_PERBUF);
   wire wr_action = apb_wr & (paddr == ADDR_ACTION);
   // cmd bit0 reload, bit1 switch (software triggers)
   wire wr_cmd    = apb_wr & (paddr == ADDR_CMD);
   wire sw_reload = wr_cmd & pwdata[0];
   wire sw_switch = wr_cmd & pwdata[1];
   wire addr_ok   = (paddr <= ADDR_CMD) & (paddr[1:0] == 2'b00);
   wire [31:0] rd_mux =
      (paddr == ADDR_CTRL)   ? ctrl_reg :
      (paddr == ADDR_STATUS) ? {30'h0, running_reg, down_reg} :
      (paddr == ADDR_COUNT)  ? {16'h0, count_reg} :
      (paddr == ADDR_CMP)    ? {16'h0, cmp_reg} :
      (paddr == ADDR_CMPBUF) ? {16'h0, cmpbuf_reg} :
      (paddr == ADDR_PER)    ? {16'h0, per_reg} :
      (paddr == ADDR_PERBUF) ? {16'h0, perbuf_reg} :
      (paddr == ADDR_ACTION) ? {26'h0, action_reg} :
      32'h0000_0000;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= apb_setup;
         pslverr <= apb_setup & ~addr_ok;
         if (apb_setup) begin
            prdata <= rd_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // quadrature step decode
   wire q_step_x1 = a_rise;
   wire q_step_x2 = a_edge;
   wire q_step_x4 = a_edge | b_edge;
   wire q_step = (quad_sel == QUAD_X1) ? q_step_x1 :
                 (quad_sel == QUAD_X2) ? q_step_x2 :
                 q_step_x4;
   // direction: a leads b gives increment
   wire q_dn_x1 = encoder_phase_b;
   wire q_dn_x4 = a_edge ? (encoder_phase_a == encoder_phase_b)
                         : (encoder_phase_a != encoder_phase_b);
   wire q_down  = (quad_sel == QUAD_X1) ? q_dn_x1 : q_dn_x4;
   wire q_ext   = (count_reg == CNT_ZERO) | (count_reg == CNT_MAX);
   wire q_tc    = is_quad & index_rise;
   // only a step onto an extreme counts: an index load to zero in up
   // mode, or entering the mode at zero, must not reload at once
   wire q_cc    = is_quad & q_ext & q_moved_reg & ~q_tc;

   ////////////////////////////////////////////////////////////////////
   // pwm counter events
   wire counting_up = (dir_sel == DIR_UP) |
                      (((dir_sel == DIR_UPDN0) | (dir_sel == DIR_UPDN1))
                       & ~down_reg);
   // sync kill needs an edge; async kill is the plain level
   wire kill_active = sync_kill ? (sync_killed_reg | kill_rise)
                                : kill_lvl;
   wire at_top  = (count_reg == per_reg);
   wire at_zero = (count_reg == CNT_ZERO);
   wire p_run   = is_pwm & running_reg & ~(stop_kill & kill_active);
   wire p_ov    = p_run & counting_up & at_top;
   wire p_un    = p_run & ~counting_up & at_zero;
   wire p_tc    = (dir_sel == DIR_UPDN0) ? p_un : (p_ov | p_un);
   wire p_cc    = p_run & (count_reg == cmp_reg);
   wire p_reload = is_pwm & (sw_reload | index_rise);
   wire center  = (dir_sel == DIR_UPDN0) | (dir_sel == DIR_UPDN1);

   ////////////////////////////////////////////////////////////////////
   // next count and direction
   always_comb begin
      count_next = count_reg;
      down_next  = down_reg;
      if (wr_count) begin
         count_next = pwdata[15:0];
      end else if (q_tc) begin
         count_next = (dir_sel == DIR_DOWN) ? per_reg : CNT_ZERO;
      end else if (q_cc) begin
         count_next = per_reg;
      end else if (is_quad & q_step) begin
         down_next  = q_down;
         count_next = q_down ? count_reg - CNT_ONE : count_reg + CNT_ONE;
      end else if (p_reload) begin
         count_next = (dir_sel == DIR_DOWN) ? per_reg : CNT_ZERO;
         down_next  = (dir_sel == DIR_DOWN);
      end else if (p_run) begin
         case (dir_sel)
            DIR_UP: begin
               count_next = at_top ? CNT_ZERO : count_reg + CNT_ONE;
            end
            DIR_DOWN: begin
               count_next = at_zero ? per_reg : count_reg - CNT_ONE;
            end
            default: begin
               if (~down_reg & at_top) begin
                  down_next  = 1'b1;
                  count_next = count_reg - CNT_ONE;
               end else if (down_reg & at_zero) begin
                  down_next  = 1'b0;
                  count_next = count_reg + CNT_ONE;
               end else begin
                  count_next = down_reg ? count_reg - CNT_ONE
                                        : count_reg + CNT_ONE;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pwm line logic
   function automatic logic apply_act(input act_t a, input logic v);
      case (a)
         ACT_SET:    apply_act = 1'b1;
         ACT_CLEAR:  apply_act = 1'b0;
         ACT_TOGGLE: apply_act = ~v;
         default:    apply_act = v;
      endcase
   endfunction

   logic line_reg, line_next;
   always_comb begin
      line_next = line_reg;
      if (p_run) begin
         if (center) begin
            if (p_tc) begin
               line_next = 1'b0;
            end else if (p_cc) begin
               line_next = ~line_reg;
            end
         end else begin
            if (p_ov) line_next = apply_act(action_reg.on_ov, line_next);
            if (p_un) line_next = apply_act(action_reg.on_un, line_next);
            if (p_cc) line_next = apply_act(action_reg.on_cc, line_next);
         end
      end
   end

   wire do_swap = p_tc & (switch_reg | sw_switch);

   ////////////////////////////////////////////////////////////////////
   // state registers
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_reg        <= CTRL_RESET;
         count_reg       <= CNT_ZERO;
         cmp_reg         <= CNT_ZERO;
         cmpbuf_reg      <= CNT_ZERO;
         per_reg         <= PER_RESET;
         perbuf_reg      <= PER_RESET;
         cap_reg         <= CNT_ZERO;
         capbuf_reg      <= CNT_ZERO;
         action_reg      <= '{ACT_NONE, ACT_NONE, ACT_NONE};
         down_reg        <= 1'b0;
         running_reg     <= 1'b0;
         switch_reg      <= 1'b0;
         sync_killed_reg <= 1'b0;
         q_moved_reg     <= 1'b0;
         line_reg        <= 1'b0;
      end else begin
         count_reg <= count_next;
         down_reg  <= down_next;
         line_reg  <= line_next;
         q_moved_reg <= is_quad & q_step & ~q_tc & ~q_cc & ~wr_count;
         if (wr_ctrl) ctrl_reg <= pwdata;
         if (wr_action) action_reg <= action_t'(pwdata[5:0]);
         if (wr_cmpbuf) cmpbuf_reg <= pwdata[15:0];
         if (wr_perbuf) perbuf_reg <= pwdata[15:0];
         if (do_swap & ctrl_reg[CTL_CCSWAP]) begin
            cmp_reg    <= cmpbuf_reg;
            cmpbuf_reg <= cmp_reg;
         end else if (wr_cmp) begin
            cmp_reg <= pwdata[15:0];
         end
         if (do_swap & ctrl_reg[CTL_PERSWAP]) begin
            per_reg    <= perbuf_reg;
            perbuf_reg <= per_reg;
         end else if (wr_per) begin
            per_reg <= pwdata[15:0];
         end
         // capture: count to capture, old capture to buffer
         if (q_tc | q_cc) begin
            cap_reg    <= count_reg;
            capbuf_reg <= cap_reg;
         end
         // a switch landing on tc is used by that tc, so it clears
         if (sw_switch & ~p_tc) begin
            switch_reg <= 1'b1;
         end else if (p_tc) begin
            switch_reg <= 1'b0;
         end
         if (p_reload) begin
            running_reg <= 1'b1;
         end else if (~enabled) begin
            running_reg <= 1'b0;
         end
         if (sync_kill & kill_rise & is_pwm) begin
            sync_killed_reg <= 1'b1;
         end else if (p_tc | ~sync_kill) begin
            sync_killed_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // registered outputs
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         line_out       <= 1'b0;
         line_out_compl <= 1'b0;
         compare_match  <= 1'b0;
         terminal_count <= 1'b0;
      end else begin
         line_out       <= is_pwm & ~kill_active & line_next;
         line_out_compl <= is_pwm & ~kill_active & ~line_next;
         compare_match  <= q_cc | p_cc;
         terminal_count <= q_tc | p_tc;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // assertions
   a_quad_reload_cc: assert property (
      @(posedge clock) disable iff (sys_rst)
      q_cc & ~wr_count |=> count_reg == $past(per_reg))
      else $error("count not reloaded after extreme");
   a_index_load: assert property (
      @(posedge clock) disable iff (sys_rst)
      q_tc & ~wr_count & dir_sel == DIR_UP |=> count_reg == CNT_ZERO)
      else $error("index did not clear count");
   a_capture_shift: assert property (
      @(posedge clock) disable iff (sys_rst)
      (q_tc | q_cc) |=> cap_reg == $past(count_reg)
                        && capbuf_reg == $past(cap_reg))
      else $error("capture shift wrong");
   a_capture_cause: assert property (
      @(posedge clock) disable iff (sys_rst)
      q_cc |=> cap_reg == CNT_ZERO || cap_reg == CNT_MAX)
      else $error("capture does not mark the extreme");
   a_dir_status: assert property (
      @(posedge clock) disable iff (sys_rst)
      is_quad & q_step & ~q_tc & ~q_cc & ~wr_count
      |=> down_reg == $past(q_down))
      else $error("direction bit wrong");
   a_x1_step: assert property (
      @(posedge clock) disable iff (sys_rst)
      is_quad & quad_sel == QUAD_X1 & a_rise & ~encoder_phase_b & ~q_tc
      & ~q_cc & ~wr_count |=> count_reg == $past(count_reg) + CNT_ONE)
      else $error("x1 increment missing");
   a_pwm_reload: assert property (
      @(posedge clock) disable iff (sys_rst)
      p_reload & ~wr_count & dir_sel == DIR_UP |=> count_reg == CNT_ZERO)
      else $error("reload did not start count at zero");
   a_kill_lines: assert property (
      @(posedge clock) disable iff (sys_rst)
      kill_active |=> ~line_out & ~line_out_compl)
      else $error("lines live during kill");
   a_kill_stop: assert property (
      @(posedge clock) disable iff (sys_rst)
      is_pwm & stop_kill & kill_active & ~wr_count & ~p_reload
      |=> count_reg == $past(count_reg))
      else $error("counter ran during stop kill");
   a_center_tc: assert property (
      @(posedge clock) disable iff (sys_rst)
      p_tc & center & ~kill_active |=> ~line_out)
      else $error("center line not cleared at tc");
   a_switch_clear: assert property (
      @(posedge clock) disable iff (sys_rst)
      p_tc & ~sw_switch |=> ~switch_reg)
      else $error("switch not cleared at tc");
   a_sync_kill: assert property (
      @(posedge clock) disable iff (sys_rst)
      sync_killed_reg & ~p_tc & sync_kill |=> sync_killed_reg)
      else $error("sync kill ended early");

endmodule

/* shared/qpwm_pkg.sv */
package qpwm_pkg;
   // counter control word layout
   localparam int CTL_UPDN_LO   = 16;
   localparam int CTL_QUAD_LO   = 20;
   localparam int CTL_FUNC_LO   = 24;
   localparam int CTL_CCSWAP    = 0;
   localparam int CTL_PERSWAP   = 1;
   localparam int CTL_STOPKILL  = 2;
   localparam int CTL_SYNCKILL  = 3;
   localparam int CTL_ENABLE    = 31;
   // register byte offsets
   localparam logic [11:0] ADDR_CTRL    = 12'h000;
   localparam logic [11:0] ADDR_STATUS  = 12'h004;
   localparam logic [11:0] ADDR_COUNT   = 12'h008;
   localparam logic [11:0] ADDR_CMP     = 12'h00c;
   localparam logic [11:0] ADDR_CMPBUF  = 12'h010;
   localparam logic [11:0] ADDR_PER     = 12'h014;
   localparam logic [11:0] ADDR_PERBUF  = 12'h018;
   localparam logic [11:0] ADDR_ACTION  = 12'h01c;
   localparam logic [11:0] ADDR_CMD     = 12'h020;
   localparam logic [15:0] CNT_ZERO     = 16'h0000;
   localparam logic [15:0] CNT_MAX      = 16'hffff;
   localparam logic [15:0] CNT_ONE      = 16'h0001;
   localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
   localparam logic [15:0] PER_RESET    = 16'h8000;

   typedef enum logic [2:0] {
      FUNC_TIMER  = 3'b000,
      FUNC_QUAD   = 3'b011,
      FUNC_PWM    = 3'b100
   } func_t;

   typedef enum logic [1:0] {
      DIR_UP      = 2'b00,
      DIR_DOWN    = 2'b01,
      DIR_UPDN0   = 2'b10,
      DIR_UPDN1   = 2'b11
   } dir_mode_t;

   typedef enum logic [1:0] {
      QUAD_X1     = 2'b00,
      QUAD_X2     = 2'b01,
      QUAD_X4     = 2'b10
   } quad_t;

   // output action codes: set, clear, toggle, none
   typedef enum logic [1:0] {
      ACT_SET     = 2'b00,
      ACT_CLEAR   = 2'b01,
      ACT_TOGGLE  = 2'b10,
      ACT_NONE    = 2'b11
   } act_t;

   typedef struct packed {
      act_t       on_cc;
      act_t       on_ov;
      act_t       on_un;
   } action_t;

   typedef struct packed {
      logic       cc;
      logic       ov;
      logic       un;
      logic       tc;
   } events_t;
endpackage

/* verification/qpwm_encoder_model.sv */
`timescale 1ns/1ns
// rotary encoder on the decoder pins; each phase pin change is held for three
// clocks so the decoder never sees two changes within one period
module qpwm_encoder_model (
   // clock
   input  wire logic clock,
   // encoder pins
   output logic      phase_a,
   output logic      phase_b,
   output logic      index_pulse
);
   logic [1:0] seq [4];

   initial begin
      phase_a = 1'b0;
      phase_b = 1'b0;
      index_pulse = 1'b0;
      seq = '{2'h2, 2'h3, 2'h1, 2'h0};
   end

   task automatic hold(input logic a, input logic b);
      @(posedge clock);
      phase_a <= a;
      phase_b <= b;
      repeat (2) @(posedge clock);
   endtask

   // one full encoder cycle; forward lets phase a lead phase b
   task automatic cycle(input bit fwd);
      for (int i = 0; i < 4; i++) begin
         if (fwd) begin
            hold(seq[i][1], seq[i][0]);
         end else begin
            hold(seq[i][0], seq[i][1]);
         end
      end
   endtask

   task automatic index();
      @(posedge clock);
      index_pulse <= 1'b1;
      repeat (2) @(posedge clock);
      index_pulse <= 1'b0;
      repeat (2) @(posedge clock);
   endtask
endmodule

/* verification/counter_quadrature_and_pwm_modes_tb.sv */
`timescale 1ns/1ns
module counter_quadrature_and_pwm_modes_tb;
   import qpwm_pkg::*;
   logic        clock, sys_rst, psel, penable, pwrite, kill_trigger;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, ph_a, ph_b, idx, lv;
   logic        line_out, line_out_compl, compare_match, terminal_count;
   int          miscompares, checks, ncc, ntc, t0, steps, base;
   logic [64:0] note;
   logic [64:0] expq [$];
   logic [9:0]  row [5];

   qpwm_counter u_dut (.clock(clock), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .count_trigger(ph_a), .start_trigger(ph_b), .reload_trigger(idx),
      .kill_trigger(kill_trigger), .line_out(line_out),
      .line_out_compl(line_out_compl), .compare_match(compare_match),
      .terminal_count(terminal_count));
   qpwm_encoder_model u_enc (.clock(clock), .phase_a(ph_a),
      .phase_b(ph_b), .index_pulse(idx));

   ////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // caller may be past either clock edge; request starts at the next rising edge, held until pready
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) chk("bus answer", 1, 0);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hffff_ffff,
                     input logic er = 1'b0);
      expq.push_back({er, m, e & m});
      bus(1'b0, a, 32'h0);
   endtask

   task automatic wait_ev(input bit cc);
      int k;
      k = 0;
      do begin
         @(negedge clock);
         k++;
      end while ((cc ? compare_match : terminal_count) !== 1'b1 && k < 300);
      if (k >= 300) chk("event wait", 1, 0);
   endtask

   function automatic logic [31:0] ctl(input logic [2:0] f,
      input logic [1:0] q, input logic [1:0] d, input logic [3:0] lo);
      return {1'h1, 4'h0, f, 2'h0, q, 2'h0, d, 12'h000, lo};
   endfunction

   ////////////////////////////////////////////////////////////////////
   always @(posedge clock) begin
      if (psel && penable && pready === 1'b1 && !pwrite && expq.size()) begin
         note = expq.pop_front();
         chk("read data", note[31:0], prdata & note[63:32]);
         chk("read error", {31'h0, note[64]}, {31'h0, pslverr});
      end
      if (compare_match === 1'b1) ncc++;
      if (terminal_count === 1'b1) ntc++;
   end

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   initial begin
      repeat (30000) @(posedge clock);
      miscompares++;
      end_sim();
   end

   initial begin
      {sys_rst, psel, penable, pwrite, kill_trigger} = 5'h10;
      {paddr, pwdata, miscompares, checks, ncc, ntc} = '0;
      // dir, cc/ov/un actions, line after tc, line after cc
      row = '{{DIR_UP, 6'h13, 2'h2}, {DIR_UP, 6'h07, 2'h1},
              {DIR_DOWN, 6'h0d, 2'h1}, {DIR_UPDN0, 6'h3f, 2'h1},
              {DIR_UPDN1, 6'h3f, 2'h1}};
      void'($urandom(79348));
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      rd(ADDR_CTRL, CTRL_RESET);
      rd(ADDR_PER, {16'h0, PER_RESET});
      rd(ADDR_PERBUF, {16'h0, PER_RESET});
      rd(ADDR_ACTION, 32'h3f);
      rd(ADDR_STATUS, 32'h0);
      rd(12'h0fc, 32'h0, 32'hffff_ffff, 1'b1);
      for (int i = 0; i < 3; i++) begin
         base = (i == 2) ? 0 : 32'h8000;
         steps = 2 + $urandom % 5;
         wr(ADDR_CTRL, ctl(FUNC_QUAD, i, i < 2, 0));
         t0 = ntc;
         u_enc.index();
         repeat (6) @(posedge clock);
         chk("index tc", t0 + 1, ntc);
         rd(ADDR_COUNT, base);
         repeat (steps) u_enc.cycle(1'b1);
         repeat (6) @(posedge clock);
         rd(ADDR_COUNT, base + steps * (1 << i));
         rd(ADDR_STATUS, 32'h0, 32'h1);
         repeat (steps - 1) u_enc.cycle(1'b0);
         repeat (6) @(posedge clock);
         rd(ADDR_COUNT, base + (1 << i));
         rd(ADDR_STATUS, 32'h1, 32'h1);
      end
      chk("no extreme", 0, ncc);
      wr(ADDR_CTRL, ctl(FUNC_QUAD, QUAD_X1, DIR_DOWN, 0));
      for (int i = 0; i < 2; i++) begin
         wr(ADDR_PER, i ? 32'h1 : 32'hfffe);
         u_enc.index();
         u_enc.cycle(i == 0);
         repeat (6) @(posedge clock);
         chk("extreme cc", i + 1, ncc);
         rd(ADDR_COUNT, i ? 32'h1 : 32'hfffe);
      end
      wr(ADDR_PER, 32'h9);
      wr(ADDR_CMP, 32'h4);
      for (int i = 0; i < 5; i++) begin
         wr(ADDR_ACTION, {26'h0, row[i][7:2]});
         wr(ADDR_CTRL, ctl(FUNC_PWM, 0, row[i][9:8], 0));
         wr(ADDR_CMD, 32'h1);
         wait_ev(1'b0);
         repeat (2) @(negedge clock);
         chk("line after tc", row[i][1], line_out);
         chk("compl after tc", !row[i][1], line_out_compl);
         wait_ev(1'b1);
         repeat (2) @(negedge clock);
         chk("line after cc", row[i][0], line_out);
      end
      // up/down mode 1 gives a tc at both ends of each half period
      t0 = ntc;
      repeat (18) @(negedge clock);
      chk("updn1 tc", t0 + 2, ntc);
      wr(ADDR_CTRL, ctl(FUNC_PWM, 0, DIR_UP, 0));
      wr(ADDR_ACTION, 32'h2f);
      wait_ev(1'b1);
      repeat (2) @(negedge clock);
      lv = line_out;
      wait_ev(1'b1);
      repeat (2) @(negedge clock);
      chk("toggle", !lv, line_out);
      // pending switch: buffers swap at the next tc, and only once
      wr(ADDR_CTRL, ctl(FUNC_PWM, 0, DIR_UP, 4'h3));
      wr(ADDR_CMPBUF, 32'h6);
      wr(ADDR_PERBUF, 32'hc);
      wr(ADDR_CMD, 32'h3);
      wait_ev(1'b0);
      repeat (2) wait_ev(1'b0);
      rd(ADDR_PER, 32'hc);
      rd(ADDR_PERBUF, 32'h9);
      rd(ADDR_CMP, 32'h6);
      rd(ADDR_CMPBUF, 32'h4);
      wr(ADDR_PER, 32'h9);
      wr(ADDR_CMP, 32'h4);
      wr(ADDR_ACTION, 32'h13);
      for (int i = 0; i < 2; i++) begin
         wr(ADDR_CTRL, ctl(FUNC_PWM, 0, DIR_UP, i ? 4'h4 : 4'h0));
         wr(ADDR_CMD, 32'h1);
         @(posedge clock);
         kill_trigger <= 1'b1;
         repeat (5) @(negedge clock);
         t0 = ntc;
         repeat (25) @(negedge clock);
         chk("killed", 0, {line_out, line_out_compl});
         chk("tc in kill", !i, ntc > t0);
         @(posedge clock);
         kill_trigger <= 1'b0;
         repeat (6) @(negedge clock);
         if (i == 0) chk("kill over", 1, line_out | line_out_compl);
      end
      wr(ADDR_CTRL, ctl(FUNC_PWM, 0, DIR_UP, 4'h8));
      wr(ADDR_CMD, 32'h1);
      wait_ev(1'b0);
      @(posedge clock);
      kill_trigger <= 1'b1;
      repeat (2) @(posedge clock);
      kill_trigger <= 1'b0;
      repeat (5) @(negedge clock);
      chk("sync kill", 0, {line_out, line_out_compl});
      wait_ev(1'b0);
      repeat (3) @(negedge clock);
      chk("sync over", 1, line_out);
      end_sim();
   end
endmodule
